// File: bench/slm_rx_model.sv
// Receiver model that checks a PRBS7 lane stream bit by bit.
`timescale 1ns/1ps
module slm_rx_model (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Lane under test
  input  wire logic        prbs_on,
  input  wire logic [31:0] lane_word,
  // Results
  output int               bits_seen,
  output int               errs
);
  logic [6:0] hist;

  // Dropping lock clears the bit count, so stale history bits never judge fresh ones.
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      errs = 0;
    if (!reset_n || !prbs_on) begin
      bits_seen = 0;
    end else begin
      for (int i = 31; i >= 0; i--) begin
        if (bits_seen >= 7 && lane_word[i] !== (hist[5] ^ hist[6]))
          errs++;
        hist = {hist[5:0], lane_word[i]};
        bits_seen++;
      end
    end
  end
endmodule : slm_rx_model

// File: bench/testbench.sv
// Self-checking bench for the serial lane mapper.
`timescale 1ns/1ps
module testbench;
  logic         ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, frame_valid, lane_valid, prbs_on;
  logic         full_power_down_input, or_flag_i_second, or_flag_q_second, sync_hdr_fec;
  logic         power_down_first_channel, power_down_second_channel, ddc_src_first, ddc_src_second;
  logic [3:0]   avs_address, avs_byteenable;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  logic [95:0]  raw_chan_first;
  logic [47:0]  raw_chan_second;
  logic [119:0] ddc_i_first, ddc_q_first;
  logic [7:0]   over_range_flag_first, over_range_flag_second;
  logic [14:0]  ddc_i_second, ddc_q_second;
  logic [255:0] a_side_lane_data, b_side_lane_data;
  logic [15:0]  lane_enable;
  int           fails, n_tests, bits_seen, errs;

  slm_lane_mapper uut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .frame_valid, .raw_chan_first, .raw_chan_second,
    .ddc_i_first, .ddc_q_first, .over_range_flag_first, .over_range_flag_second, .ddc_i_second,
    .ddc_q_second, .or_flag_i_second, .or_flag_q_second, .full_power_down_input, .power_down_first_channel,
    .power_down_second_channel, .ddc_src_first, .ddc_src_second, .sync_hdr_fec, .a_side_lane_data,
    .b_side_lane_data, .lane_enable, .lane_valid);
  slm_rx_model rx (.ref_clk, .reset_n, .prbs_on, .lane_word(a_side_lane_data[31:0]), .bits_seen, .errs);

  // ********************************************
  // Bus, frame and compare helpers
  // ********************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request stays up until waitrequest is seen low at a rising edge.
  task bus(input logic wr, input logic [3:0] adr, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= adr;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task frame;
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    @(posedge ref_clk);
    chk({31'h0, lane_valid}, 32'h1);
  endtask : frame

  // ********************************************
  // Scenarios
  // ********************************************
  task t_eight_bit;
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0122);
    frame();
    chk({a_side_lane_data[63:56], a_side_lane_data[31:24]}, 32'h7812);
    chk({b_side_lane_data[63:56], b_side_lane_data[31:24]}, 32'hAB45);
    chk({16'h0, lane_enable}, 32'h0303);
    $display("eight-bit mapping done");
  endtask : t_eight_bit

  task t_ddc_words;
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_011A);
    frame();
    chk({a_side_lane_data[127:112], a_side_lane_data[31:16]}, 32'h8888_2223);
    chk({16'h0, b_side_lane_data[63:48]}, 32'h0AAB);
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0727);
    frame();
    chk(a_side_lane_data[31:0], 32'h2223_1554);
    chk(b_side_lane_data[31:0], 32'hE001_0002);
    chk({ddc_src_first, sync_hdr_fec, lane_enable}, 32'h3_0101);
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0722);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, ddc_src_first}, 32'h0);
    $display("ddc word mapping done");
  endtask : t_ddc_words

  // Writes the control word, then sends one frame in that mode.
  task send(input logic [31:0] ctrl);
    bus(1'b1, slm_pkg::ADDR_CTRL, ctrl);
    frame();
  endtask : send

  task t_other_modes;
    send(32'h0000_0120);
    chk({a_side_lane_data[31:16], a_side_lane_data[95:80]}, 32'h1237_F654);
    chk({b_side_lane_data[63:48], b_side_lane_data[95:80]}, 32'hBC32_1987);
    send(32'h0000_0921);
    chk({a_side_lane_data[63:48], b_side_lane_data[95:80]}, 32'h5678_9ABC);
    send(32'h0000_0123);
    chk({8'h0, a_side_lane_data[63:56], a_side_lane_data[31:24], b_side_lane_data[63:56]}, 32'h0045_1222);
    send(32'h0000_0125);
    chk({a_side_lane_data[63:48], b_side_lane_data[63:48]}, 32'h1554_0002);
    send(32'h0000_0126);
    chk({a_side_lane_data[31:16], b_side_lane_data[31:16]}, 32'h2223_1554);
    send(32'h0000_0138);
    chk(a_side_lane_data[31:0], 32'h2223_1554);
    send(32'h0000_013F);
    chk({16'h0, lane_enable}, 32'h0F0F);
    send(32'h0000_011B);
    chk({16'h0, lane_enable}, 32'hFFFF);
    $display("other modes done");
  endtask : t_other_modes

  task t_patterns;
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0022);
    bus(1'b1, slm_pkg::ADDR_TEST, 32'h6);
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0120);
    repeat (2) @(posedge ref_clk);
    chk(a_side_lane_data[31:0], slm_pkg::CLOCK_WORD);
    chk({16'h0, lane_enable}, 32'h0707);
    bus(1'b1, slm_pkg::ADDR_TEST, 32'h0);
    bus(1'b0, slm_pkg::ADDR_TEST, 32'h0);
    chk({28'h0, rd[3:0]}, 32'h6);
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0022);
    bus(1'b1, slm_pkg::ADDR_TEST, 32'h1);
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_0122);
    repeat (3) @(posedge ref_clk);
    prbs_on <= 1'b1;
    repeat (20) @(posedge ref_clk);
    prbs_on <= 1'b0;
    chk({31'h0, bits_seen > 400}, 32'h1);
    chk(32'(errs), 32'h0);
    chk({31'h0, a_side_lane_data[31:0] !== a_side_lane_data[63:32]}, 32'h1);
    $display("test patterns done");
  endtask : t_patterns

  task t_power;
    bus(1'b1, slm_pkg::ADDR_CTRL, 32'h0000_3923);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, power_down_first_channel}, 32'h1);
    chk({30'h0, power_down_second_channel, ddc_src_second}, 32'h3);
    // Calibration stays in the background here, so no converter-off setting is needed.
    full_power_down_input <= 1'b1;
    bus(1'b0, slm_pkg::ADDR_STATUS, 32'h0);
    chk({15'h0, rd[16], lane_enable}, 32'h1_0000);
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
    full_power_down_input <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({16'h0, lane_enable}, 32'h0303);
    $display("power-down done");
  endtask : t_power

  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    close_out();
  end

  initial begin
    {reset_n, avs_read, avs_write, frame_valid, prbs_on, full_power_down_input} = 6'h0;
    {avs_address, avs_writedata, fails, n_tests} = '0;
    avs_byteenable = 4'hF;
    raw_chan_first = 96'h123_456_789_ABC_DEF_321_654_987;
    raw_chan_second = 48'h111_222_333_444;
    ddc_i_first = {15'h1111, 15'h2222, 15'h3333, 15'h4444, 60'h0};
    ddc_q_first = {15'h0AAA, 15'h0555, 90'h0};
    {over_range_flag_first, over_range_flag_second} = 16'h0502;
    {ddc_i_second, or_flag_i_second, ddc_q_second, or_flag_q_second} = 32'hE001_0002;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_eight_bit();
    t_ddc_words();
    t_other_modes();
    t_patterns();
    t_power();
    close_out();
  end
endmodule : testbench

// File: hdl/slm_lane_mapper.sv
// Transmit lane mapper with serializer test patterns and an Avalon-MM register slave.
`timescale 1ns/1ps
module slm_lane_mapper (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset_n,
  // Avalon-MM register slave
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  // Converter sample words, one set per frame strobe
  input  wire logic          frame_valid,
  input  wire logic [95:0]   raw_chan_first,
  input  wire logic [47:0]   raw_chan_second,
  input  wire logic [119:0]  ddc_i_first,
  input  wire logic [119:0]  ddc_q_first,
  input  wire logic [7:0]    over_range_flag_first,
  input  wire logic [7:0]    over_range_flag_second,
  input  wire logic [14:0]   ddc_i_second,
  input  wire logic [14:0]   ddc_q_second,
  input  wire logic          or_flag_i_second,
  input  wire logic          or_flag_q_second,
  // Power control
  input  wire logic          full_power_down_input,
  output logic               power_down_first_channel,
  output logic               power_down_second_channel,
  output logic               ddc_src_first,
  output logic               ddc_src_second,
  output logic               sync_hdr_fec,
  // Lane outputs, octet 0 in bits 31:24 of each lane word
  output logic [255:0]       a_side_lane_data,
  output logic [255:0]       b_side_lane_data,
  output logic [15:0]        lane_enable,
  output logic               lane_valid
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [5:0]          mode;
    logic                link_en;
    logic                fec;
    logic                bind1;
    logic                bind2;
    logic                pd_first;
    logic                pd_second;
    logic                cfg_pd;
    logic [3:0]          test;
    logic                ack;
    logic                waitreq;
    logic [31:0]         rdata;
    logic                src1;
    logic                src2;
    logic                chan_pd1;
    logic                chan_pd2;
    logic [15:0]         lane_en;
    logic                valid;
    logic [7:0][31:0]    lane_a;
    logic [7:0][31:0]    lane_b;
    logic [15:0][31:0]   hist;
  } slm_state_t;

  slm_state_t st_reg;
  slm_state_t st_next;

  // Places a 15-bit word above its over-range flag.
  function automatic logic [15:0] pack15(input logic [14:0] w, input logic o);
    pack15 = {w, o};
  endfunction : pack15

  // Generates 32 bits of the selected sequence; the first bit lands in bit 31.
  function automatic logic [63:0] prbs_step(input logic [31:0] h, input logic [3:0] sel);
    logic [31:0] hh;
    logic [31:0] w;
    int          p;
    int          q;
    logic        b;
    hh = h;
    w  = '0;
    case (sel)
      slm_pkg::TEST_PRBS7:  begin p = 6;  q = 7;  end
      slm_pkg::TEST_PRBS9:  begin p = 5;  q = 9;  end
      slm_pkg::TEST_PRBS15: begin p = 14; q = 15; end
      slm_pkg::TEST_PRBS23: begin p = 18; q = 23; end
      default:              begin p = 28; q = 31; end
    endcase
    for (int i = 0; i < 32; i++) begin
      b         = hh[p-1] ^ hh[q-1];
      w[31-i]   = b;
      hh        = {hh[30:0], b};
    end
    prbs_step = {w, hh};
  endfunction : prbs_step

  logic        dual_mode;
  logic        mode_ok;
  logic        pd_all;
  logic        is_prbs;
  logic [15:0] mode_mask;
  logic [31:0] ctrl_img;
  logic [31:0] stat_img;
  logic [31:0] be_mask;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic [11:0] pa [4];
    logic [11:0] pb [4];
    logic [11:0] s  [8];
    logic [63:0] step;
    logic [47:0] cat_a;
    logic [47:0] cat_b;
    logic [15:0] w_ai;
    logic [15:0] w_aq;
    logic [15:0] w_bi;
    logic [15:0] w_bq;
    pa      = '{default: '0};
    pb      = '{default: '0};
    s       = '{default: '0};
    step    = '0;
    cat_a   = '0;
    cat_b   = '0;
    w_ai    = '0;
    w_aq    = '0;
    w_bi    = '0;
    w_bq    = '0;
    st_next = st_reg;
    dual_mode = 1'b0;
    mode_ok   = 1'b1;
    mode_mask = 16'h0000;
    case (st_reg.mode)
      slm_pkg::MODE_34: mode_mask = 16'h0303;
      slm_pkg::MODE_35: begin mode_mask = 16'h0303; dual_mode = 1'b1; end
      slm_pkg::MODE_32: mode_mask = 16'h0707;
      slm_pkg::MODE_33: begin mode_mask = 16'h0707; dual_mode = 1'b1; end
      slm_pkg::MODE_26, slm_pkg::MODE_54, slm_pkg::MODE_63: mode_mask = 16'h0F0F;
      slm_pkg::MODE_27: mode_mask = 16'hFFFF;
      slm_pkg::MODE_37: begin mode_mask = 16'h0303; dual_mode = 1'b1; end
      slm_pkg::MODE_38: mode_mask = 16'h0101;
      slm_pkg::MODE_39, slm_pkg::MODE_56: begin mode_mask = 16'h0101; dual_mode = 1'b1; end
      default: mode_ok = 1'b0;
    endcase
    pd_all  = full_power_down_input | st_reg.cfg_pd;
    is_prbs = (st_reg.test >= slm_pkg::TEST_PRBS7) && (st_reg.test <= slm_pkg::TEST_PRBS31);
    ctrl_img = '0;
    ctrl_img[slm_pkg::CTRL_MODE_LSB +: 6] = st_reg.mode;
    ctrl_img[slm_pkg::CTRL_LINK_EN]   = st_reg.link_en;
    ctrl_img[slm_pkg::CTRL_FEC]       = st_reg.fec;
    ctrl_img[slm_pkg::CTRL_BIND1]     = st_reg.bind1;
    ctrl_img[slm_pkg::CTRL_BIND2]     = st_reg.bind2;
    ctrl_img[slm_pkg::CTRL_PD_FIRST]  = st_reg.pd_first;
    ctrl_img[slm_pkg::CTRL_PD_SECOND] = st_reg.pd_second;
    ctrl_img[slm_pkg::CTRL_CFG_PD]    = st_reg.cfg_pd;
    stat_img = '0;
    stat_img[15:0] = st_reg.lane_en;
    stat_img[slm_pkg::STAT_PD]      = pd_all;
    stat_img[slm_pkg::STAT_MODE_OK] = mode_ok;
    stat_img[slm_pkg::STAT_SRC1]    = st_reg.src1;
    stat_img[slm_pkg::STAT_SRC2]    = st_reg.src2;
    be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    // Bus slave: one wait cycle, then the access completes with waitrequest low.
    st_next.ack     = (avs_read | avs_write) & ~st_reg.ack;
    st_next.waitreq = ~st_next.ack;
    if (st_next.ack) begin
      case (avs_address)
        slm_pkg::ADDR_CTRL:   st_next.rdata = ctrl_img;
        slm_pkg::ADDR_TEST:   st_next.rdata = {28'h0000000, st_reg.test};
        slm_pkg::ADDR_STATUS: st_next.rdata = stat_img;
        default:              st_next.rdata = 32'h00000000;
      endcase
    end
    if (st_reg.ack && avs_write) begin
      if (avs_address == slm_pkg::ADDR_CTRL) begin
        ctrl_img          = (ctrl_img & ~be_mask) | (avs_writedata & be_mask);
        st_next.mode      = ctrl_img[slm_pkg::CTRL_MODE_LSB +: 6];
        st_next.link_en   = ctrl_img[slm_pkg::CTRL_LINK_EN];
        st_next.fec       = ctrl_img[slm_pkg::CTRL_FEC];
        st_next.bind1     = ctrl_img[slm_pkg::CTRL_BIND1];
        st_next.bind2     = ctrl_img[slm_pkg::CTRL_BIND2];
        st_next.pd_first  = ctrl_img[slm_pkg::CTRL_PD_FIRST];
        st_next.pd_second = ctrl_img[slm_pkg::CTRL_PD_SECOND];
        st_next.cfg_pd    = ctrl_img[slm_pkg::CTRL_CFG_PD];
      end
      // A running link keeps its pattern; a late change is dropped.
      if ((avs_address == slm_pkg::ADDR_TEST) && !st_reg.link_en && avs_byteenable[0]) begin
        st_next.test = avs_writedata[3:0];
      end
    end

    // Channel binding only acts in dual-channel modes.
    st_next.src1     = st_reg.bind1 & dual_mode;
    st_next.src2     = st_reg.bind2 & dual_mode;
    st_next.chan_pd1 = pd_all | (st_reg.pd_first & dual_mode);
    st_next.chan_pd2 = pd_all | (st_reg.pd_second & dual_mode);
    for (int k = 0; k < 8; k++) begin
      s[k] = raw_chan_first[12*(7-k) +: 12];
    end
    for (int k = 0; k < 4; k++) begin
      pa[k] = st_reg.src1 ? raw_chan_second[12*(3-k) +: 12] : s[k];
      pb[k] = st_reg.src2 ? s[k] : raw_chan_second[12*(3-k) +: 12];
    end
    w_ai = pack15(ddc_i_first[119:105], over_range_flag_first[0]);
    w_aq = pack15(ddc_q_first[119:105], over_range_flag_second[0]);
    w_bi = pack15(ddc_i_second, or_flag_i_second);
    w_bq = pack15(ddc_q_second, or_flag_q_second);

    // Lane contents and enables; the mode and power-down decide which lanes run.
    st_next.lane_en = (pd_all || !mode_ok) ? 16'h0000 : mode_mask;
    st_next.valid   = 1'b0;
    if (pd_all || !st_reg.link_en || !mode_ok) begin
      st_next.lane_a = '0;
      st_next.lane_b = '0;
    end else if (is_prbs) begin
      st_next.valid = 1'b1;
      for (int l = 0; l < 16; l++) begin
        step = prbs_step(st_reg.hist[l], st_reg.test);
        st_next.hist[l] = step[31:0];
        if (l < 8) begin
          st_next.lane_a[l] = mode_mask[l] ? step[63:32] : 32'h00000000;
        end else begin
          st_next.lane_b[l-8] = mode_mask[l] ? step[63:32] : 32'h00000000;
        end
      end
    end else if (st_reg.test == slm_pkg::TEST_CLOCK) begin
      st_next.valid = 1'b1;
      for (int l = 0; l < 8; l++) begin
        st_next.lane_a[l] = mode_mask[l] ? slm_pkg::CLOCK_WORD : 32'h00000000;
        st_next.lane_b[l] = mode_mask[l+8] ? slm_pkg::CLOCK_WORD : 32'h00000000;
      end
    end else if (frame_valid) begin
      st_next.valid  = 1'b1;
      st_next.lane_a = '0;
      st_next.lane_b = '0;
      // Octet 0 sits in bits 31:24 so it leaves first, high nibble leading.
      case (st_reg.mode)
        slm_pkg::MODE_34: begin
          st_next.lane_a[0][31:24] = s[0][11:4];
          st_next.lane_a[1][31:24] = s[2][11:4];
          st_next.lane_b[0][31:24] = s[1][11:4];
          st_next.lane_b[1][31:24] = s[3][11:4];
        end
        slm_pkg::MODE_35: begin
          st_next.lane_a[0][31:24] = pa[0][11:4];
          st_next.lane_a[1][31:24] = pa[1][11:4];
          st_next.lane_b[0][31:24] = pb[0][11:4];
          st_next.lane_b[1][31:24] = pb[1][11:4];
        end
        slm_pkg::MODE_32, slm_pkg::MODE_33: begin
          if (st_reg.mode == slm_pkg::MODE_32) begin
            cat_a = {s[0], s[2], s[4], s[6]};
            cat_b = {s[1], s[3], s[5], s[7]};
          end else begin
            cat_a = {pa[0], pa[1], pa[2], pa[3]};
            cat_b = {pb[0], pb[1], pb[2], pb[3]};
          end
          for (int l = 0; l < 3; l++) begin
            st_next.lane_a[l][31:16] = cat_a[47-16*l -: 16];
            st_next.lane_b[l][31:16] = cat_b[47-16*l -: 16];
          end
        end
        slm_pkg::MODE_26, slm_pkg::MODE_54, slm_pkg::MODE_63, slm_pkg::MODE_27: begin
          for (int l = 0; l < 8; l++) begin
            if (mode_mask[l]) begin
              st_next.lane_a[l][31:16] = pack15(ddc_i_first[119-15*l -: 15], over_range_flag_first[l]);
              st_next.lane_b[l][31:16] = pack15(ddc_q_first[119-15*l -: 15], over_range_flag_second[l]);
            end
          end
        end
        slm_pkg::MODE_37: begin
          st_next.lane_a[0][31:16] = w_ai;
          st_next.lane_a[1][31:16] = w_aq;
          st_next.lane_b[0][31:16] = w_bi;
          st_next.lane_b[1][31:16] = w_bq;
        end
        slm_pkg::MODE_38: begin
          st_next.lane_a[0][31:16] = w_ai;
          st_next.lane_b[0][31:16] = w_aq;
        end
        default: begin
          st_next.lane_a[0] = {w_ai, w_aq};
          st_next.lane_b[0] = {w_bi, w_bq};
        end
      endcase
    end
    // Sequences restart from per-lane seeds whenever the link is down.
    if (!st_reg.link_en || !is_prbs) begin
      for (int l = 0; l < 16; l++) begin
        st_next.hist[l] = 32'(l + 1);
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg         <= '0;
      st_reg.mode    <= slm_pkg::MODE_RESET;
      st_reg.test    <= slm_pkg::TEST_RESET;
      st_reg.waitreq <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata              = st_reg.rdata;
  assign avs_waitrequest           = st_reg.waitreq;
  assign power_down_first_channel  = st_reg.chan_pd1;
  assign power_down_second_channel = st_reg.chan_pd2;
  assign ddc_src_first             = st_reg.src1;
  assign ddc_src_second            = st_reg.src2;
  assign sync_hdr_fec              = st_reg.fec;
  assign a_side_lane_data          = st_reg.lane_a;
  assign b_side_lane_data          = st_reg.lane_b;
  assign lane_enable               = st_reg.lane_en;
  assign lane_valid                = st_reg.valid;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_pd_lanes_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    full_power_down_input |=> (lane_enable == 16'h0000) && !lane_valid && power_down_first_channel)
    else $error("lanes still enabled during power-down");
  chk_mode34_octets: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.mode == slm_pkg::MODE_34) && st_reg.link_en && !pd_all && (st_reg.test == slm_pkg::TEST_OFF)
      && frame_valid |=> (a_side_lane_data[63:56] == $past(raw_chan_first[71:64]))
      && (b_side_lane_data[31:24] == $past(raw_chan_first[83:76])))
    else $error("mode 34 sample placement wrong");
  chk_mode38_words: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.mode == slm_pkg::MODE_38) && st_reg.link_en && !pd_all && (st_reg.test == slm_pkg::TEST_OFF)
      && frame_valid |=> (a_side_lane_data[31:16] == {$past(ddc_i_first[119:105]), $past(over_range_flag_first[0])}))
    else $error("mode 38 in-phase word wrong");
  chk_mode39_quad: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.mode == slm_pkg::MODE_39) && st_reg.link_en && !pd_all && (st_reg.test == slm_pkg::TEST_OFF)
      && frame_valid |=> (b_side_lane_data[15:0] == {$past(ddc_q_second), $past(or_flag_q_second)}))
    else $error("mode 39 quadrature octets wrong");
  chk_mode27_lanes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.mode == slm_pkg::MODE_27) && !pd_all |=> (lane_enable == 16'hFFFF))
    else $error("mode 27 does not enable sixteen lanes");
  chk_test_lanes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.mode == slm_pkg::MODE_32) && !pd_all && (st_reg.test != slm_pkg::TEST_OFF)
      ##1 $stable(st_reg.mode) && !pd_all |-> (lane_enable == 16'h0707))
    else $error("test mode altered lane count");
  chk_clock_word: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.test == slm_pkg::TEST_CLOCK) && st_reg.link_en && !pd_all && mode_ok
      |=> lane_valid && (a_side_lane_data[31:0] == 32'hFF00FF00))
    else $error("clock pattern wrong");
  chk_test_locked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_reg.link_en && st_reg.ack && avs_write && (avs_address == slm_pkg::ADDR_TEST) |=> $stable(st_reg.test))
    else $error("test select changed while link enabled");
  chk_bind_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !dual_mode ##1 !$past(dual_mode) |-> !ddc_src_first && !ddc_src_second)
    else $error("redundant routing in single-channel mode");
  chk_prbs7_recur: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (st_reg.test == slm_pkg::TEST_PRBS7) && st_reg.link_en && !pd_all && mode_ok ##1 lane_valid
      |-> (a_side_lane_data[24] == (a_side_lane_data[30] ^ a_side_lane_data[31])))
    else $error("prbs7 recurrence broken");
endmodule : slm_lane_mapper

// File: hdl/slm_pkg.sv
// Constants shared by the serial lane mapper.
package slm_pkg;
  // ****************************************************************
  // Register map (byte addresses) and field positions
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_TEST      = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;
  localparam int         CTRL_MODE_LSB  = 0;
  localparam int         CTRL_LINK_EN   = 8;
  localparam int         CTRL_FEC       = 9;
  localparam int         CTRL_BIND1     = 10;
  localparam int         CTRL_BIND2     = 11;
  localparam int         CTRL_PD_FIRST  = 12;
  localparam int         CTRL_PD_SECOND = 13;
  localparam int         CTRL_CFG_PD    = 14;
  localparam int         STAT_PD        = 16;
  localparam int         STAT_MODE_OK   = 17;
  localparam int         STAT_SRC1      = 18;
  localparam int         STAT_SRC2      = 19;
  localparam logic [5:0] MODE_RESET     = 6'h00;
  localparam logic [3:0] TEST_RESET     = 4'h0;
  // ****************************************************************
  // Link modes
  // ****************************************************************
  localparam logic [5:0] MODE_26 = 6'h1A;
  localparam logic [5:0] MODE_27 = 6'h1B;
  localparam logic [5:0] MODE_32 = 6'h20;
  localparam logic [5:0] MODE_33 = 6'h21;
  localparam logic [5:0] MODE_34 = 6'h22;
  localparam logic [5:0] MODE_35 = 6'h23;
  localparam logic [5:0] MODE_37 = 6'h25;
  localparam logic [5:0] MODE_38 = 6'h26;
  localparam logic [5:0] MODE_39 = 6'h27;
  localparam logic [5:0] MODE_54 = 6'h36;
  localparam logic [5:0] MODE_56 = 6'h38;
  localparam logic [5:0] MODE_63 = 6'h3F;
  // ****************************************************************
  // Test pattern selection and lane geometry
  // ****************************************************************
  localparam logic [3:0]  TEST_OFF    = 4'h0;
  localparam logic [3:0]  TEST_PRBS7  = 4'h1;
  localparam logic [3:0]  TEST_PRBS9  = 4'h2;
  localparam logic [3:0]  TEST_PRBS15 = 4'h3;
  localparam logic [3:0]  TEST_PRBS23 = 4'h4;
  localparam logic [3:0]  TEST_PRBS31 = 4'h5;
  localparam logic [3:0]  TEST_CLOCK  = 4'h6;
  localparam logic [31:0] CLOCK_WORD  = 32'hFF00FF00;
  localparam int          SIDE_LANES  = 8;
  localparam int          LANE_W      = 32;
endpackage : slm_pkg
